/* File: verilog/swc_pkg.sv */
// Purpose: Shared constants and types for the sleep and wake controller.
// Assumes: 32-bit AXI4-Lite register port, one clock domain.
// Notes: Register offsets are byte addresses of aligned words.
package swc_pkg;

  localparam int unsigned SWC_ADDR_W = 4;
  localparam int unsigned SWC_DATA_W = 32;

  // Register map.
  localparam logic [SWC_ADDR_W-1:0] SWC_OFS_CTRL = 4'h0;
  localparam logic [SWC_ADDR_W-1:0] SWC_OFS_STAT = 4'h4;
  localparam int unsigned SWC_WORD_LSB = 2;

  // Control register fields.
  localparam int unsigned SWC_CTRL_RETURN_BIT = 1;
  localparam int unsigned SWC_CTRL_DEEP_BIT = 2;
  localparam int unsigned SWC_CTRL_PEND_BIT = 4;
  localparam logic SWC_CTRL_RESET_BIT = 1'b0;

  // Status register fields.
  localparam int unsigned SWC_STAT_STATE_LSB = 0;
  localparam int unsigned SWC_STAT_DEEP_BIT = 2;
  localparam int unsigned SWC_STAT_CAUSE_LSB = 3;
  localparam int unsigned SWC_STAT_COUNT_LSB = 16;
  localparam int unsigned SWC_CAUSE_W = 4;
  localparam int unsigned SWC_COUNT_MAX_W = 16;

  // Wake cause encoding, one bit per source.
  localparam logic [SWC_CAUSE_W-1:0] SWC_CAUSE_NONE = 4'h0;
  localparam logic [SWC_CAUSE_W-1:0] SWC_CAUSE_EXC = 4'h1;
  localparam logic [SWC_CAUSE_W-1:0] SWC_CAUSE_EVENT = 4'h2;
  localparam logic [SWC_CAUSE_W-1:0] SWC_CAUSE_PEND = 4'h4;
  localparam logic [SWC_CAUSE_W-1:0] SWC_CAUSE_DEBUG = 4'h8;

  // AXI responses.
  localparam logic [1:0] SWC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SWC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SWC_ST_RUN,
    SWC_ST_WFI,
    SWC_ST_WFE,
    SWC_ST_EXIT
  } swc_state_t;

endpackage : swc_pkg

/* File: verilog/swc_ctrl_if.sv */
// Purpose: Carries control bits and status between register file and core logic.
// Assumes: One clock domain.
// Notes: The event flag deliberately has no place here.
interface swc_ctrl_if;
  import swc_pkg::*;
  logic sleep_on_return_bit;
  logic pending_sets_event_bit;
  logic deep_sleep_select;
  logic [SWC_DATA_W-1:0] status;

  modport regs (
    output sleep_on_return_bit,
    output pending_sets_event_bit,
    output deep_sleep_select,
    input status
  );

  modport core (
    input sleep_on_return_bit,
    input pending_sets_event_bit,
    input deep_sleep_select,
    output status
  );
endinterface : swc_ctrl_if

/* File: verilog/swc_event_flag.sv */
// Purpose: One-bit event register set by event sources and cleared by wait-for-event.
// Assumes: Set and clear are single-cycle strobes.
// Notes: A set in the clearing cycle wins, so no event is lost.
module swc_event_flag
  import swc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic set_evt,
  input wire logic clr_evt,
  output logic flag
);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag <= 1'b0;
    end else if (ce) begin
      if (set_evt) begin
        flag <= 1'b1;
      end else if (clr_evt) begin
        flag <= 1'b0;
      end
    end
  end

endmodule : swc_event_flag

/* File: verilog/swc_axil_regs.sv */
// Purpose: AXI4-Lite slave holding the control register and returning status.
// Assumes: One write and one read outstanding at most.
// Notes: Unmapped addresses answer SLVERR; writes to status are ignored.
module swc_axil_regs
  import swc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [SWC_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [SWC_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [SWC_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [SWC_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  swc_ctrl_if.regs ctl
);

  logic aw_held_reg;
  logic w_held_reg;
  logic [SWC_ADDR_W-1:0] aw_addr_reg;
  logic [SWC_DATA_W-1:0] w_data_reg;
  logic w_lane0_reg;
  logic ret_reg;
  logic deep_reg;
  logic pend_reg;

  function automatic logic swc_hit(input logic [SWC_ADDR_W-1:0] a,
                                   input logic [SWC_ADDR_W-1:0] ofs);
    swc_hit = (a[SWC_ADDR_W-1:SWC_WORD_LSB] == ofs[SWC_ADDR_W-1:SWC_WORD_LSB]);
  endfunction : swc_hit

  assign ctl.sleep_on_return_bit = ret_reg;
  assign ctl.deep_sleep_select = deep_reg;
  assign ctl.pending_sets_event_bit = pend_reg;

  // Write channel: address and data are taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_lane0_reg <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= SWC_RESP_OKAY;
      ret_reg <= SWC_CTRL_RESET_BIT;
      deep_reg <= SWC_CTRL_RESET_BIT;
      pend_reg <= SWC_CTRL_RESET_BIT;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata;
        w_lane0_reg <= wstrb[0];
        wready <= 1'b0;
      end
      if (aw_held_reg && w_held_reg && !bvalid) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid <= 1'b1;
        if (swc_hit(aw_addr_reg, SWC_OFS_CTRL)) begin
          bresp <= SWC_RESP_OKAY;
          if (w_lane0_reg) begin
            ret_reg <= w_data_reg[SWC_CTRL_RETURN_BIT];
            deep_reg <= w_data_reg[SWC_CTRL_DEEP_BIT];
            pend_reg <= w_data_reg[SWC_CTRL_PEND_BIT];
          end
        end else if (swc_hit(aw_addr_reg, SWC_OFS_STAT)) begin
          bresp <= SWC_RESP_OKAY;
        end else begin
          bresp <= SWC_RESP_SLVERR;
        end
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read channel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= SWC_RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= SWC_RESP_OKAY;
        rdata <= '0;
        if (swc_hit(araddr, SWC_OFS_CTRL)) begin
          rdata[SWC_CTRL_RETURN_BIT] <= ret_reg;
          rdata[SWC_CTRL_DEEP_BIT] <= deep_reg;
          rdata[SWC_CTRL_PEND_BIT] <= pend_reg;
        end else if (swc_hit(araddr, SWC_OFS_STAT)) begin
          rdata <= ctl.status;
        end else begin
          rresp <= SWC_RESP_SLVERR;
        end
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule : swc_axil_regs

/* File: verilog/swc_sleep_ctrl.sv */
// Purpose: Sleep entry and wake-up control for the processor core.
// Assumes: Pipeline strobes are one-cycle pulses, synchronous to aclk.
// Notes: Outputs change at the edge after the cause; all state freezes while ce is low.
//
// Contract
// - Wait-for-interrupt sleeps at once unless a wake condition already holds.
// - Wait-for-event with event flag clear sleeps.
// - Wait-for-event with event flag set clears it and keeps running.
// - Send-event sets the event flag.
// - Event flag has no software read or write path.
// - Sleep-on-return set: last handler return enters sleep immediately.
// - Interrupt or return sleep wakes only on an exception able to enter.
// - Priority mask set, fault mask clear: higher interrupt wakes, handler deferred.
// - Wait-for-event sleep wakes on an exception able to enter.
// - Pending-sets-event: any newly pending interrupt wakes wait-for-event sleep.
// - Spurious wake-ups such as debug wake the core; software re-enters sleep.
// - Deep-sleep select chooses ordinary or deep sleep.
// - Ordinary sleep gates processor clock; deep stops system clock, PLL, flash.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
module swc_sleep_ctrl
  import swc_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [SWC_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [SWC_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [SWC_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [SWC_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic wait_for_interrupt_op,
  input wire logic wait_for_event_op,
  input wire logic send_event_op,
  input wire logic ext_event,
  input wire logic last_handler_return,
  input wire logic exc_entry_ok,
  input wire logic irq_above_prio,
  input wire logic new_pend,
  input wire logic priority_mask_bit,
  input wire logic fault_mask_bit,
  input wire logic debug_wake,
  output logic core_halt,
  output logic sleep_req,
  output logic sleep_deep,
  output logic proc_clk_stop,
  output logic sys_clk_stop,
  output logic pll_power_down,
  output logic flash_power_down,
  output logic handler_defer
);

  if (CNT_W < 1 || CNT_W > SWC_COUNT_MAX_W) begin : g_bad_cnt
    $error("swc_sleep_ctrl: CNT_W must lie between 1 and 16.");
  end

  swc_ctrl_if ctl ();

  swc_state_t state_reg;
  swc_state_t state_next;
  logic evt_flag;
  logic evt_set;
  logic evt_clr;
  logic evt_src;
  logic wake_irq;
  logic wake_wfe;
  logic wake_deferred;
  logic run;
  logic wfi_go;
  logic wfe_go;
  logic exit_go;
  logic deep_reg;
  logic [SWC_CAUSE_W-1:0] cause_reg;
  logic [SWC_CAUSE_W-1:0] cause_next;
  logic [CNT_W-1:0] count_reg;
  logic sleeping_next;

  swc_axil_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .ctl(ctl.regs)
  );

  // Only instruction strobes and event sources reach the flag; the register file cannot.
  swc_event_flag u_evt (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .set_evt(evt_set),
    .clr_evt(evt_clr),
    .flag(evt_flag)
  );

  // Masks let a higher interrupt wake while its handler waits on the priority mask.
  assign wake_deferred = priority_mask_bit && !fault_mask_bit && irq_above_prio;
  assign wake_irq = exc_entry_ok || wake_deferred;
  assign evt_src = send_event_op || ext_event ||
                   (ctl.pending_sets_event_bit && new_pend);
  assign wake_wfe = wake_irq || evt_src;

  // One operation per cycle is expected; wait-for-interrupt has priority if they collide.
  assign run = (state_reg == SWC_ST_RUN);
  assign wfi_go = run && wait_for_interrupt_op;
  assign wfe_go = run && !wait_for_interrupt_op && wait_for_event_op;
  assign exit_go = run && !wait_for_interrupt_op && !wait_for_event_op &&
                   last_handler_return && ctl.sleep_on_return_bit;

  // An event seen by a sleeping or entering wait-for-event is consumed, not stored.
  assign evt_set = evt_src && (state_reg != SWC_ST_WFE) && !wfe_go;
  assign evt_clr = wfe_go && evt_flag;

  always_comb begin
    state_next = state_reg;
    cause_next = SWC_CAUSE_NONE;
    unique case (state_reg)
      SWC_ST_RUN: begin
        if (wfi_go) begin
          if (!wake_irq && !debug_wake) begin
            state_next = SWC_ST_WFI;
          end
        end else if (wfe_go) begin
          if (!evt_flag && !wake_wfe && !debug_wake) begin
            state_next = SWC_ST_WFE;
          end
        end else if (exit_go) begin
          if (!wake_irq && !debug_wake) begin
            state_next = SWC_ST_EXIT;
          end
        end
      end
      SWC_ST_WFI, SWC_ST_EXIT: begin
        if (wake_irq) begin
          state_next = SWC_ST_RUN;
          cause_next = SWC_CAUSE_EXC;
        end else if (debug_wake) begin
          state_next = SWC_ST_RUN;
          cause_next = SWC_CAUSE_DEBUG;
        end
      end
      SWC_ST_WFE: begin
        if (wake_irq) begin
          state_next = SWC_ST_RUN;
          cause_next = SWC_CAUSE_EXC;
        end else if (ctl.pending_sets_event_bit && new_pend) begin
          state_next = SWC_ST_RUN;
          cause_next = SWC_CAUSE_PEND;
        end else if (evt_src) begin
          state_next = SWC_ST_RUN;
          cause_next = SWC_CAUSE_EVENT;
        end else if (debug_wake) begin
          state_next = SWC_ST_RUN;
          cause_next = SWC_CAUSE_DEBUG;
        end
      end
    endcase
  end

  assign sleeping_next = (state_next != SWC_ST_RUN);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= SWC_ST_RUN;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // Deep select is caught at entry so a write during sleep cannot change the mode under it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      deep_reg <= 1'b0;
    end else if (ce && run && sleeping_next) begin
      deep_reg <= ctl.deep_sleep_select;
    end
  end

  // Clock and power controls follow the next state, so they drop at the waking edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_halt <= 1'b0;
      sleep_req <= 1'b0;
      sleep_deep <= 1'b0;
      proc_clk_stop <= 1'b0;
      sys_clk_stop <= 1'b0;
      pll_power_down <= 1'b0;
      flash_power_down <= 1'b0;
    end else if (ce) begin
      core_halt <= sleeping_next;
      sleep_req <= sleeping_next;
      proc_clk_stop <= sleeping_next;
      if (run && sleeping_next) begin
        sleep_deep <= ctl.deep_sleep_select;
        sys_clk_stop <= ctl.deep_sleep_select;
        pll_power_down <= ctl.deep_sleep_select;
        flash_power_down <= ctl.deep_sleep_select;
      end else if (!sleeping_next) begin
        sleep_deep <= 1'b0;
        sys_clk_stop <= 1'b0;
        pll_power_down <= 1'b0;
        flash_power_down <= 1'b0;
      end
    end
  end

  // Handler entry is held off for as long as only the masked interrupt is waiting.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      handler_defer <= 1'b0;
    end else if (ce) begin
      handler_defer <= wake_deferred && !exc_entry_ok;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_reg <= SWC_CAUSE_NONE;
    end else if (ce && cause_next != SWC_CAUSE_NONE) begin
      cause_reg <= cause_next;
    end
  end

  // The entry counter wraps; software reading it only compares successive values.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= '0;
    end else if (ce && run && sleeping_next) begin
      count_reg <= count_reg + CNT_W'(1);
    end
  end

  always_comb begin
    ctl.status = '0;
    ctl.status[SWC_STAT_STATE_LSB +: 2] = state_reg;
    ctl.status[SWC_STAT_DEEP_BIT] = deep_reg;
    ctl.status[SWC_STAT_CAUSE_LSB +: SWC_CAUSE_W] = cause_reg;
    ctl.status[SWC_STAT_COUNT_LSB +: CNT_W] = count_reg;
  end

  // Outputs are registered, so checks look one edge past the cause.
  a_wfi_sleeps: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && wfi_go && !wake_irq && !debug_wake |=> core_halt && state_reg == SWC_ST_WFI)
    else $error("Wait-for-interrupt did not enter sleep.");

  a_wfi_skip_sleep: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && wfi_go && wake_irq |=> !core_halt && run)
    else $error("Wait-for-interrupt slept despite a wake condition.");

  a_wfe_sleeps: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && wfe_go && !evt_flag && !wake_wfe && !debug_wake |=> core_halt)
    else $error("Wait-for-event with clear flag did not sleep.");

  a_wfe_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && wfe_go && evt_flag |=> !evt_flag && !core_halt)
    else $error("Wait-for-event with set flag did not clear and continue.");

  a_sev_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && run && send_event_op && !wait_for_event_op |=> evt_flag)
    else $error("Send-event did not set the event flag.");

  a_exit_sleeps: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && exit_go && !wake_irq && !debug_wake |=> state_reg == SWC_ST_EXIT && core_halt)
    else $error("Return with sleep-on-return set did not sleep.");

  a_sleep_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && (state_reg == SWC_ST_WFI || state_reg == SWC_ST_EXIT) &&
    !wake_irq && !debug_wake |=> core_halt)
    else $error("Interrupt sleep ended without an exception or debug wake.");

  a_mask_defer: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && priority_mask_bit && !fault_mask_bit && irq_above_prio && !exc_entry_ok
    |=> handler_defer)
    else $error("Masked higher interrupt did not defer its handler.");

  a_pend_wakes: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && state_reg == SWC_ST_WFE && ctl.pending_sets_event_bit && new_pend
    |=> !core_halt && !sleep_req)
    else $error("New pending interrupt did not wake event sleep.");

  a_deep_controls: assert property (@(posedge aclk) disable iff (!aresetn)
    core_halt |-> proc_clk_stop && sleep_req &&
    (sys_clk_stop == sleep_deep) && (pll_power_down == sleep_deep) &&
    (flash_power_down == sleep_deep))
    else $error("Clock and power controls disagree with the sleep mode.");

  a_deep_select: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && run && sleeping_next |=> sleep_deep == $past(ctl.deep_sleep_select))
    else $error("Sleep mode does not follow deep-sleep select.");

  a_wfe_wakes: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && state_reg == SWC_ST_WFE &&
    (wake_wfe || debug_wake)
    |=> !core_halt && run)
    else $error("Event sleep missed a wake source.");

  a_debug_wakes: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !run && debug_wake
    |=> !core_halt)
    else $error("Debug wake did not end sleep.");

  a_defer_release: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && exc_entry_ok
    |=> !handler_defer)
    else $error("Handler stayed deferred after entry became possible.");

  a_wake_drops_req: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !run && wake_irq
    |=> !sleep_req && !proc_clk_stop && !sys_clk_stop)
    else $error("Sleep request stayed up after a wake.");

  a_deep_held: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !run && sleeping_next
    |=> $stable(sleep_deep))
    else $error("Sleep mode changed during sleep.");

endmodule : swc_sleep_ctrl

/* File: tb/swc_core_model.sv */
// Purpose: Behavioural pipeline and interrupt controller facing the sleep controller.
// Assumes: Driven by the bench through its tasks, one request at a time.
// Notes: A halted pipeline issues no instructions, so instruction pulses wait for wake.
module swc_core_model (
  input wire logic aclk,
  input wire logic core_halt,
  output logic wait_for_interrupt_op,
  output logic wait_for_event_op,
  output logic send_event_op,
  output logic ext_event,
  output logic last_handler_return,
  output logic exc_entry_ok,
  output logic irq_above_prio,
  output logic new_pend,
  output logic priority_mask_bit,
  output logic fault_mask_bit,
  output logic debug_wake
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] op_vec = 6'h00;
  logic [4:0] irq_lv = 5'h00;
  logic irq_pend;
  logic irq_en;
  logic irq_hi;
  logic pend_q = 1'b0;
  assign {debug_wake, ext_event, last_handler_return} = op_vec[5:3];
  assign {send_event_op, wait_for_event_op, wait_for_interrupt_op} = op_vec[2:0];
  assign {irq_pend, irq_en, irq_hi, priority_mask_bit, fault_mask_bit} = irq_lv;
  // Priority test ignores the masks, so a masked wake can still be seen.
  assign irq_above_prio = irq_pend & irq_en & irq_hi;
  // Either mask blocks entry.
  assign exc_entry_ok = irq_above_prio & !priority_mask_bit & !fault_mask_bit;
  // Any rising pending line is new, whatever its enable or priority.
  assign new_pend = irq_pend & !pend_q;
  always_ff @(posedge aclk) begin
    pend_q <= irq_pend;
  end
  // Kinds 0 to 3 are instructions; 4 and 5 are event and debug sources.
  task pulse(input int k);
    @(posedge aclk);
    while (k < 4 && core_halt === 1'b1) @(posedge aclk);
    op_vec <= 6'h01 << k;
    @(posedge aclk);
    op_vec <= 6'h00;
  endtask : pulse
  task irq(input logic p, input logic e, input logic h, input logic pm, input logic fm);
    @(posedge aclk);
    irq_lv <= {p, e, h, pm, fm};
  endtask : irq
endmodule : swc_core_model

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the sleep and wake controller.
// Assumes: Register port timing as handed over; one clock at 125 MHz.
// Notes: Sleep outputs are compared as one group so no single line slips by.
module tb
  import swc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int K_IRQ = 0, K_EVT = 1, K_SEV = 2, K_RET = 3, K_EXT = 4, K_DBG = 5;
  localparam logic [6:0] S_RUN = 7'h00, S_LITE = 7'h70, S_DEEP = 7'h7f;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [SWC_ADDR_W-1:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic wait_for_interrupt_op, wait_for_event_op, send_event_op, ext_event;
  logic last_handler_return, exc_entry_ok, irq_above_prio, new_pend;
  logic priority_mask_bit, fault_mask_bit, debug_wake;
  logic core_halt, sleep_req, sleep_deep, proc_clk_stop, sys_clk_stop;
  logic pll_power_down, flash_power_down, handler_defer;
  logic [6:0] sleep_vec;
  int error_cnt = 0;
  int checks_done = 0;
  assign sleep_vec = {core_halt, sleep_req, proc_clk_stop, sleep_deep, sys_clk_stop,
                      pll_power_down, flash_power_down};

  swc_sleep_ctrl #(.CNT_W(16)) i_dut (
    .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .wait_for_interrupt_op, .wait_for_event_op, .send_event_op, .ext_event,
    .last_handler_return, .exc_entry_ok, .irq_above_prio, .new_pend, .priority_mask_bit,
    .fault_mask_bit, .debug_wake, .core_halt, .sleep_req, .sleep_deep, .proc_clk_stop,
    .sys_clk_stop, .pll_power_down, .flash_power_down, .handler_defer
  );
  swc_core_model i_core (
    .aclk, .core_halt, .wait_for_interrupt_op, .wait_for_event_op, .send_event_op,
    .ext_event, .last_handler_return, .exc_entry_ok, .irq_above_prio, .new_pend,
    .priority_mask_bit, .fault_mask_bit, .debug_wake
  );

  initial begin
    forever #4 aclk = ~aclk;
  end

  task settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : settle
  task chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word
  task chk_sleep(input logic [6:0] exp, input string what);
    chk_word(32'(sleep_vec), 32'(exp), what);
  endtask : chk_sleep
  // Valid and payload hold until their own ready edge; bready stays up until bvalid.
  task axi_wr(input logic [SWC_ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (1) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : axi_wr
  task axi_rd(input logic [SWC_ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (1) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd
  task wrap_up;
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  // The whole sequence needs well under two thousand cycles.
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    $display("ERROR %0t: watchdog expired", $time);
    wrap_up;
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    settle(1);
    chk_sleep(S_RUN, "reset outputs");
    axi_rd(SWC_OFS_CTRL, rd, resp);
    chk_word(rd, 32'h0, "control reset");
    axi_rd(4'h8, rd, resp);
    chk_word(32'(resp), 32'(SWC_RESP_SLVERR), "unmapped read");
    axi_wr(4'h8, 32'h0, resp);
    chk_word(32'(resp), 32'(SWC_RESP_SLVERR), "unmapped write");
    i_core.pulse(K_IRQ);
    settle(1);
    chk_sleep(S_LITE, "interrupt wait sleeps");
    i_core.irq(1, 1, 1, 0, 0);
    settle(2);
    chk_sleep(S_RUN, "exception wake");
    i_core.pulse(K_IRQ);
    settle(2);
    chk_sleep(S_RUN, "wake already true");
    i_core.irq(0, 0, 0, 1, 1);
    i_core.pulse(K_IRQ);
    i_core.irq(1, 1, 1, 1, 1);
    settle(4);
    chk_sleep(S_LITE, "fault mask keeps sleep");
    i_core.irq(1, 1, 1, 1, 0);
    settle(2);
    chk_sleep(S_RUN, "priority mask wake");
    chk_word(32'(handler_defer), 32'h1, "handler deferred");
    i_core.irq(1, 1, 1, 0, 0);
    settle(2);
    chk_word(32'(handler_defer), 32'h0, "handler released");
    i_core.irq(0, 0, 0, 0, 0);
    i_core.pulse(K_EVT);
    settle(1);
    chk_sleep(S_LITE, "event wait sleeps");
    axi_rd(SWC_OFS_STAT, rd, resp);
    chk_word(rd & 32'h3, 32'(SWC_ST_WFE), "event sleep state");
    i_core.irq(1, 1, 1, 0, 0);
    settle(2);
    chk_sleep(S_RUN, "event wait exception wake");
    axi_rd(SWC_OFS_STAT, rd, resp);
    chk_word((rd >> SWC_STAT_CAUSE_LSB) & 32'hf, 32'(SWC_CAUSE_EXC), "wake cause");
    i_core.irq(0, 0, 0, 0, 0);
    i_core.pulse(K_SEV);
    i_core.pulse(K_EVT);
    settle(2);
    chk_sleep(S_RUN, "set flag skips sleep");
    i_core.pulse(K_EVT);
    settle(1);
    chk_sleep(S_LITE, "flag was cleared");
    i_core.pulse(K_DBG);
    settle(2);
    chk_sleep(S_RUN, "debug wake");
    i_core.pulse(K_IRQ);
    settle(1);
    chk_sleep(S_LITE, "sleep re-entered");
    i_core.pulse(K_DBG);
    settle(2);
    chk_sleep(S_RUN, "second debug wake");
    i_core.pulse(K_EVT);
    i_core.irq(1, 0, 0, 0, 0);
    settle(4);
    chk_sleep(S_LITE, "pending ignored without bit");
    axi_wr(SWC_OFS_CTRL, 32'h1 << SWC_CTRL_PEND_BIT, resp);
    chk_word(32'(resp), 32'(SWC_RESP_OKAY), "control write");
    i_core.irq(0, 0, 0, 0, 0);
    i_core.irq(1, 0, 0, 0, 0);
    settle(2);
    chk_sleep(S_RUN, "disabled pending wakes");
    i_core.irq(0, 0, 0, 0, 0);
    axi_wr(SWC_OFS_CTRL, 32'hffffffff, resp);
    axi_rd(SWC_OFS_CTRL, rd, resp);
    chk_word(rd & 32'h16, 32'h16, "control bits");
    i_core.pulse(K_EVT);
    settle(1);
    chk_sleep(S_DEEP, "deep sleep, flag not written");
    i_core.pulse(K_EXT);
    settle(2);
    chk_sleep(S_RUN, "event source wake");
    i_core.pulse(K_RET);
    settle(1);
    chk_sleep(S_DEEP, "return sleep");
    i_core.irq(1, 1, 1, 0, 0);
    settle(2);
    chk_sleep(S_RUN, "return sleep wake");
    axi_rd(SWC_OFS_STAT, rd, resp);
    chk_word(rd, 32'h0008000c, "status after return wake");
    i_core.irq(0, 0, 0, 0, 0);
    axi_wr(SWC_OFS_CTRL, 32'h0, resp);
    i_core.pulse(K_RET);
    settle(2);
    chk_sleep(S_RUN, "return without bit");
    @(posedge aclk);
    ce <= 1'b0;
    i_core.pulse(K_IRQ);
    settle(2);
    chk_sleep(S_RUN, "frozen while disabled");
    @(posedge aclk);
    ce <= 1'b1;
    settle(2);
    wrap_up;
  end
endmodule : tb
